/* rtl/sls_pkg.sv */
// shared constants for the link sync control and status block
package sls_pkg;

   // ------------------------------------------------------------
   // register map (8-bit registers, 12-bit address)
   // ------------------------------------------------------------
   localparam int         ADDR_W          = 12;
   localparam int         DATA_W          = 8;
   localparam logic [11:0] ADDR_LINK_PAGE  = 12'h300;
   localparam logic [11:0] ADDR_LANE_SYNC  = 12'h473;
   localparam logic [11:0] ADDR_RX_CTRL    = 12'h475;
   localparam logic [11:0] ADDR_IRQ_STATUS = 12'h4f0;
   localparam logic [11:0] ADDR_IRQ_ENABLE = 12'h4f1;
   localparam logic [11:0] ADDR_IRQ_CLEAR  = 12'h4f2;

   // ------------------------------------------------------------
   // link_receiver_control fields and register reset values
   // ------------------------------------------------------------
   localparam int         CTRL_SOFT_RESET_BIT = 3;
   localparam int         CTRL_FORCE_SYNC_BIT = 2;
   localparam int         CTRL_REPLACE_EN_BIT = 0;
   localparam logic [7:0] CTRL_RESET_VAL      = 8'h01;
   localparam logic [7:0] CTRL_WRITE_MASK     = 8'h0d;
   localparam logic [7:0] LANE_SYNC_RESET_VAL = 8'h00;
   localparam logic [7:0] LINK_PAGE_RESET_VAL = 8'h00;
   localparam logic [7:0] IRQ_RESET_VAL       = 8'h00;

   // ------------------------------------------------------------
   // interrupt layout: low nibble sync lost, high nibble achieved
   // ------------------------------------------------------------
   localparam int         IRQ_LOST_BASE     = 0;
   localparam int         IRQ_ACHIEVED_BASE = 4;
   localparam int         MAX_LINKS         = 4;

endpackage : sls_pkg

/* rtl/sls_link_regs.sv */
// per-link control register, lane sync flags and link-side outputs
`timescale 1ns/1ps
module sls_link_regs
   import sls_pkg::*;
#(
   parameter int NUM_LANES = 8
)
(
   // clock and reset
   input  wire logic                 sys_clk,
   input  wire logic                 rst,
   // register access for this link
   input  wire logic                 ctrl_wr,
   input  wire logic [DATA_W-1:0]    wdata,
   output logic      [DATA_W-1:0]    ctrl_q,
   output logic      [NUM_LANES-1:0] lane_flags_q,
   // receiver side
   input  wire logic [NUM_LANES-1:0] lane_sync_in,
   input  wire logic                 own_sync_req,
   output logic                      soft_reset_q,
   output logic                      sync_request_q,
   output logic                      replace_en_q,
   // events
   output logic                      ev_lost_q,
   output logic                      ev_achieved_q
);

   logic [DATA_W-1:0]    ctrl_d;
   logic [NUM_LANES-1:0] lane_flags_d;
   logic                 soft_reset_d;
   logic                 sync_request_d;
   logic                 replace_en_d;
   logic                 ev_lost_d;
   logic                 ev_achieved_d;

   // ------------------------------------------------------------
   // next-state logic
   // ------------------------------------------------------------
   always_comb
   begin
      ctrl_d = ctrl_q;
      if (ctrl_wr)
         ctrl_d = wdata & CTRL_WRITE_MASK;
      soft_reset_d = ctrl_q[CTRL_SOFT_RESET_BIT];
      sync_request_d = ctrl_q[CTRL_FORCE_SYNC_BIT] | own_sync_req;
      replace_en_d = ctrl_q[CTRL_REPLACE_EN_BIT];
      // flags follow lanes, cleared in soft reset
      lane_flags_d = soft_reset_q ? '0 : lane_sync_in;
      // events are suppressed while the receiver is held in reset
      ev_lost_d     = !soft_reset_q && |(lane_flags_q & ~lane_flags_d);
      ev_achieved_d = !soft_reset_q && (&lane_flags_d) && !(&lane_flags_q);
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         ctrl_q         <= CTRL_RESET_VAL;
         lane_flags_q   <= NUM_LANES'(LANE_SYNC_RESET_VAL);
         soft_reset_q   <= 1'b0;
         sync_request_q <= 1'b0;
         replace_en_q   <= CTRL_RESET_VAL[CTRL_REPLACE_EN_BIT];
         ev_lost_q      <= 1'b0;
         ev_achieved_q  <= 1'b0;
      end
      else
      begin
         ctrl_q         <= ctrl_d;
         lane_flags_q   <= lane_flags_d;
         soft_reset_q   <= soft_reset_d;
         sync_request_q <= sync_request_d;
         replace_en_q   <= replace_en_d;
         ev_lost_q      <= ev_lost_d;
         ev_achieved_q  <= ev_achieved_d;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   sequence ctrl_set_replace;
      ctrl_wr && wdata[CTRL_REPLACE_EN_BIT];
   endsequence

   sequence ctrl_clr_replace;
      ctrl_wr && !wdata[CTRL_REPLACE_EN_BIT];
   endsequence

   chk_soft_clears_flags: assert property (
      @(posedge sys_clk) disable iff (rst)
      soft_reset_q |=> lane_flags_q == '0)
      else $error("lane flags not cleared in soft reset");

   chk_force_sync_out: assert property (
      @(posedge sys_clk) disable iff (rst)
      ctrl_q[CTRL_FORCE_SYNC_BIT] |=> sync_request_q)
      else $error("forced sync request not asserted");

   chk_replace_follow: assert property (
      @(posedge sys_clk) disable iff (rst)
      (ctrl_set_replace |=> ##1 replace_en_q) and
      (ctrl_clr_replace |=> ##1 !replace_en_q))
      else $error("replacement enable does not follow control bit");

   chk_flag_track: assert property (
      @(posedge sys_clk) disable iff (rst)
      !soft_reset_q |=> lane_flags_q == $past(lane_sync_in))
      else $error("lane flag does not track lane status");

endmodule : sls_link_regs

/* rtl/sls_top.sv */
// link sync control and status: paged registers and interrupt
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/1ps
module sls_top
   import sls_pkg::*;
#(
   parameter int NUM_LINKS = 2,
   parameter int NUM_LANES = 8
)
(
   // clock and reset
   input  wire logic                           sys_clk,
   input  wire logic                           rst,
   // register port
   input  wire logic [ADDR_W-1:0]              reg_addr,
   input  wire logic [DATA_W-1:0]              reg_wdata,
   input  wire logic                           reg_wr,
   input  wire logic                           reg_rd,
   output logic      [DATA_W-1:0]              reg_rdata,
   // receiver status in, one lane group per link
   input  wire logic [NUM_LINKS*NUM_LANES-1:0] lane_sync_in,
   input  wire logic [NUM_LINKS-1:0]           rx_sync_req_in,
   // receiver controls out
   output logic      [NUM_LINKS-1:0]           rx_soft_reset,
   output logic      [NUM_LINKS-1:0]           sync_request,
   output logic      [NUM_LINKS-1:0]           errored_frame_replace_en,
   // interrupt
   output logic                                irq
);

   // ------------------------------------------------------------
   // page decode
   // ------------------------------------------------------------
   function automatic logic page_valid(input logic [DATA_W-1:0] page);
      page_valid = (int'(page) < NUM_LINKS);
   endfunction : page_valid

   logic [DATA_W-1:0]    link_page_q;
   logic [DATA_W-1:0]    link_page_d;
   logic [DATA_W-1:0]    link_ctrl   [NUM_LINKS];
   logic [NUM_LANES-1:0] link_flags  [NUM_LINKS];
   logic [NUM_LINKS-1:0] ctrl_wr_sel;
   logic [DATA_W-1:0]    events;
   logic [DATA_W-1:0]    irq_status_q;
   logic [DATA_W-1:0]    irq_status_d;
   logic [DATA_W-1:0]    irq_enable_q;
   logic [DATA_W-1:0]    irq_enable_d;
   logic                 irq_d;
   logic [DATA_W-1:0]    rdata_d;
   logic [DATA_W-1:0]    sel_ctrl;
   logic [DATA_W-1:0]    sel_flags;

   // ------------------------------------------------------------
   // per-link instances
   // ------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < NUM_LINKS; gi++)
      begin : g_link
         // write reaches only the paged link
         assign ctrl_wr_sel[gi] = reg_wr && (reg_addr == ADDR_RX_CTRL)
                                  && (int'(link_page_q) == gi);
         sls_link_regs #(
            .NUM_LANES (NUM_LANES)
         ) u_link (
            .sys_clk        (sys_clk),
            .rst            (rst),
            .ctrl_wr        (ctrl_wr_sel[gi]),
            .wdata          (reg_wdata),
            .ctrl_q         (link_ctrl[gi]),
            .lane_flags_q   (link_flags[gi]),
            .lane_sync_in   (lane_sync_in[gi*NUM_LANES +: NUM_LANES]),
            .own_sync_req   (rx_sync_req_in[gi]),
            .soft_reset_q   (rx_soft_reset[gi]),
            .sync_request_q (sync_request[gi]),
            .replace_en_q   (errored_frame_replace_en[gi]),
            .ev_lost_q      (events[IRQ_LOST_BASE + gi]),
            .ev_achieved_q  (events[IRQ_ACHIEVED_BASE + gi])
         );
      end
      for (gi = NUM_LINKS; gi < MAX_LINKS; gi++)
      begin : g_unused
         assign events[IRQ_LOST_BASE + gi]     = 1'b0;
         assign events[IRQ_ACHIEVED_BASE + gi] = 1'b0;
      end
   endgenerate

   // ------------------------------------------------------------
   // paged read select
   // ------------------------------------------------------------
   always_comb
   begin
      sel_ctrl  = '0;
      sel_flags = '0;
      for (int i = 0; i < NUM_LINKS; i++)
      begin
         if (int'(link_page_q) == i)
         begin
            // all eight lanes, six and seven on top
            sel_ctrl  = link_ctrl[i];
            sel_flags = DATA_W'(link_flags[i]);
         end
      end
   end

   // ------------------------------------------------------------
   // register and interrupt next state
   // ------------------------------------------------------------
   always_comb
   begin
      link_page_d  = link_page_q;
      irq_enable_d = irq_enable_q;
      irq_status_d = irq_status_q;
      rdata_d      = '0;
      if (reg_wr && reg_addr == ADDR_LINK_PAGE)
         link_page_d = reg_wdata;
      if (reg_wr && reg_addr == ADDR_IRQ_ENABLE)
         irq_enable_d = reg_wdata;
      // a clear in the same cycle as a new event loses to the event
      if (reg_wr && reg_addr == ADDR_IRQ_CLEAR)
         irq_status_d = irq_status_d & ~reg_wdata;
      irq_status_d = irq_status_d | events;
      irq_d        = |(irq_status_q & irq_enable_q);
      if (reg_rd)
      begin
         unique case (reg_addr)
            ADDR_LINK_PAGE:  rdata_d = link_page_q;
            ADDR_LANE_SYNC:  rdata_d = page_valid(link_page_q) ?
                                       sel_flags : '0;
            // reserved bits are zero in storage
            ADDR_RX_CTRL:    rdata_d = page_valid(link_page_q) ?
                                       sel_ctrl : '0;
            ADDR_IRQ_STATUS: rdata_d = irq_status_q;
            ADDR_IRQ_ENABLE: rdata_d = irq_enable_q;
            default:         rdata_d = '0;
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         link_page_q  <= LINK_PAGE_RESET_VAL;
         irq_enable_q <= IRQ_RESET_VAL;
         irq_status_q <= IRQ_RESET_VAL;
         irq          <= 1'b0;
         reg_rdata    <= '0;
      end
      else
      begin
         link_page_q  <= link_page_d;
         irq_enable_q <= irq_enable_d;
         irq_status_q <= irq_status_d;
         irq          <= irq_d;
         reg_rdata    <= rdata_d;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   sequence ctrl_read;
      reg_rd && reg_addr == ADDR_RX_CTRL;
   endsequence

   sequence flags_read;
      reg_rd && reg_addr == ADDR_LANE_SYNC && page_valid(link_page_q);
   endsequence

   chk_reserved_read_zero: assert property (
      @(posedge sys_clk) disable iff (rst)
      ctrl_read |=> reg_rdata[7:4] == 4'h0 && reg_rdata[1] == 1'b0)
      else $error("reserved control bits read nonzero");

   chk_page_route: assert property (
      @(posedge sys_clk) disable iff (rst)
      (reg_wr && reg_addr == ADDR_RX_CTRL && link_page_q == 8'h00
       && NUM_LINKS > 0)
      |=> link_ctrl[0] == ($past(reg_wdata) & CTRL_WRITE_MASK))
      else $error("control write did not reach paged link");

   chk_upper_lanes_read: assert property (
      @(posedge sys_clk) disable iff (rst)
      flags_read |=> reg_rdata[7:6] == $past(sel_flags[7:6]))
      else $error("lanes six and seven misread");

   chk_irq_level: assert property (
      @(posedge sys_clk) disable iff (rst)
      |(irq_status_q & irq_enable_q) |=> irq)
      else $error("interrupt not raised for enabled status");

endmodule : sls_top

/* tb/sls_tx_model.sv */
// far-side transmitter model: lanes report sync after a fixed latency
`timescale 1ns/1ps
module sls_tx_model
#(
   parameter int NUM_LINKS = 2,
   parameter int LAT       = 4
)
(
   // clock and reset
   input  wire logic                   sys_clk,
   input  wire logic                   rst,
   // request from the receiver, lanes the bench lets come up
   input  wire logic [NUM_LINKS-1:0]   sync_request,
   input  wire logic [NUM_LINKS*8-1:0] lane_mask,
   // lane sync state seen by the receiver
   output logic      [NUM_LINKS*8-1:0] lane_sync
);
   int cnt [NUM_LINKS];

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         lane_sync <= '0;
         for (int i = 0; i < NUM_LINKS; i++)
            cnt[i] <= 0;
      end
      else
      begin
         for (int i = 0; i < NUM_LINKS; i++)
         begin
            // a request restarts the handshake, so every lane drops
            if (sync_request[i])
            begin
               cnt[i]              <= 0;
               lane_sync[i*8 +: 8] <= 8'h00;
            end
            else if (cnt[i] < LAT)
               cnt[i] <= cnt[i] + 1;
            else
               lane_sync[i*8 +: 8] <= lane_mask[i*8 +: 8];
         end
      end
   end
endmodule : sls_tx_model

/* tb/sls_top_tb.sv */
// self-checking bench for the link sync control and status block
`timescale 1ns/1ps
module sls_top_tb
   import sls_pkg::*;
;
   logic              sys_clk;
   logic              rst;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata;
   logic              reg_wr;
   logic              reg_rd;
   logic [DATA_W-1:0] reg_rdata;
   logic [15:0]       lane_sync_in;
   logic [15:0]       lane_mask;
   logic [1:0]        rx_sync_req_in;
   logic [1:0]        rx_soft_reset;
   logic [1:0]        sync_request;
   logic [1:0]        errored_frame_replace_en;
   logic              irq;
   logic [7:0]        rd_val;
   int                n_errors;
   int                samples_checked;

   sls_top #(.NUM_LINKS(2), .NUM_LANES(8)) DUT (.sys_clk(sys_clk),
      .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .lane_sync_in(lane_sync_in), .rx_sync_req_in(rx_sync_req_in),
      .rx_soft_reset(rx_soft_reset), .sync_request(sync_request),
      .errored_frame_replace_en(errored_frame_replace_en), .irq(irq));

   sls_tx_model #(.NUM_LINKS(2), .LAT(4)) far_end (.sys_clk(sys_clk),
      .rst(rst), .sync_request(sync_request), .lane_mask(lane_mask),
      .lane_sync(lane_sync_in));

   // ------------------------------------------------------------
   // bus cycles and comparison
   // ------------------------------------------------------------
   task automatic chk(input string n, input logic [7:0] s, e);
      samples_checked++;
      if (s !== e)
      begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask : chk

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr

   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [11:0] a);
      @(posedge sys_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      rd_val = reg_rdata;
   endtask : rd

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : cyc

   task automatic set_mask(input logic [15:0] m);
      @(posedge sys_clk);
      lane_mask <= m;
   endtask : set_mask

   task automatic finish_test();
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : finish_test

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset_vals();
      rd(ADDR_RX_CTRL);
      chk("ctrl reset", rd_val, CTRL_RESET_VAL);
      rd(ADDR_LANE_SYNC);
      chk("flags reset", rd_val, 8'h00);
      chk("replace out", 8'(errored_frame_replace_en), 8'h03);
      chk("sync out", 8'(sync_request), 8'h00);
      wr(12'h123, 8'haa);
      rd(12'h123);
      chk("unmapped", rd_val, 8'h00);
   endtask : t_reset_vals

   task automatic t_ctrl();
      wr(ADDR_RX_CTRL, 8'hff);
      rd(ADDR_RX_CTRL);
      chk("ctrl reserved", rd_val, 8'h0d);
      chk("soft reset out", 8'(rx_soft_reset), 8'h01);
      chk("force sync out", 8'(sync_request), 8'h01);
      // replacement is only touched while the receiver is held
      wr(ADDR_RX_CTRL, 8'h08);
      cyc(2);
      chk("replace off", 8'(errored_frame_replace_en), 8'h02);
      wr(ADDR_RX_CTRL, 8'h09);
      wr(ADDR_RX_CTRL, 8'h01);
      cyc(2);
      chk("outs idle", {5'h00, rx_soft_reset[0], sync_request[0],
          errored_frame_replace_en[0]}, 8'h01);
      @(posedge sys_clk);
      rx_sync_req_in <= 2'b01;
      cyc(2);
      chk("own request", 8'(sync_request), 8'h01);
      @(posedge sys_clk);
      rx_sync_req_in <= 2'b00;
   endtask : t_ctrl

   task automatic t_irq();
      wr(ADDR_IRQ_ENABLE, 8'h10);
      set_mask(16'h00ff);
      cyc(10);
      chk("irq raised", 8'(irq), 8'h01);
      rd(ADDR_IRQ_STATUS);
      chk("achieved status", rd_val, 8'h10);
      wr(ADDR_IRQ_CLEAR, 8'h10);
      cyc(2);
      chk("irq cleared", 8'(irq), 8'h00);
   endtask : t_irq

   task automatic t_pages();
      rd(ADDR_LANE_SYNC);
      chk("link0 flags", rd_val, 8'hff);
      set_mask(16'h5aff);
      wr(ADDR_LINK_PAGE, 8'h01);
      cyc(6);
      rd(ADDR_LANE_SYNC);
      chk("link1 flags", rd_val, 8'h5a);
      // replacement stays set: the receiver is not held here
      wr(ADDR_RX_CTRL, 8'h05);
      cyc(2);
      chk("paged force", 8'(sync_request), 8'h02);
      wr(ADDR_RX_CTRL, 8'h01);
      wr(ADDR_LINK_PAGE, 8'h00);
      rd(ADDR_RX_CTRL);
      chk("link0 ctrl kept", rd_val, 8'h01);
      set_mask(16'h5a7f);
      cyc(8);
      rd(ADDR_LANE_SYNC);
      chk("lane7 lost", rd_val, 8'h7f);
      rd(ADDR_IRQ_STATUS);
      chk("lost status", rd_val, 8'h03);
      chk("irq masked", 8'(irq), 8'h00);
   endtask : t_pages

   task automatic t_soft_flags();
      wr(ADDR_RX_CTRL, 8'h09);
      cyc(3);
      rd(ADDR_LANE_SYNC);
      chk("flags held", rd_val, 8'h00);
      wr(ADDR_RX_CTRL, 8'h01);
      cyc(3);
      rd(ADDR_LANE_SYNC);
      chk("flags back", rd_val, 8'h7f);
   endtask : t_soft_flags

   // a page with no link behind it reads zero and drops writes
   task automatic t_bad_page();
      wr(ADDR_LINK_PAGE, 8'h02);
      rd(ADDR_LINK_PAGE);
      chk("page readback", rd_val, 8'h02);
      wr(ADDR_RX_CTRL, 8'h05);
      cyc(2);
      chk("dropped write", 8'(sync_request), 8'h00);
      rd(ADDR_RX_CTRL);
      chk("no link ctrl", rd_val, 8'h00);
      rd(ADDR_LANE_SYNC);
      chk("no link flags", rd_val, 8'h00);
      rd(ADDR_IRQ_ENABLE);
      chk("irq enable", rd_val, 8'h10);
      wr(ADDR_LINK_PAGE, 8'h00);
      rd(ADDR_RX_CTRL);
      chk("link0 untouched", rd_val, 8'h01);
   endtask : t_bad_page

   initial
   begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   initial
   begin
      rst             = 1'b1;
      reg_addr        = '0;
      reg_wdata       = '0;
      reg_wr          = 1'b0;
      reg_rd          = 1'b0;
      lane_mask       = '0;
      rx_sync_req_in  = '0;
      n_errors        = 0;
      samples_checked = 0;
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      t_reset_vals();
      t_ctrl();
      t_irq();
      t_pages();
      t_soft_flags();
      t_bad_page();
      finish_test();
   end

   // the whole run needs about 120 cycles
   initial
   begin
      #20000;
      n_errors++;
      finish_test();
   end
endmodule : sls_top_tb
